// ---- design/spb_sequencer.sv ----
// setpoint engine: twenty setpoints, continuous compare plus ordered batch sequence
// assumes weight inputs are in primary units, synchronous to clk; start and permit
// pins are asynchronous, active high at the port
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spb_cfg.svh"

module spb_sequencer
    import spb_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `SPB_TICK_NS / `SPB_CLK_NS
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [`SPB_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [`SPB_VAL_W-1:0] grossWeight,
    input wire logic signed [`SPB_VAL_W-1:0] netWeight,
    input wire logic weightUpdate,
    input wire logic standstill,
    input wire logic batchStartPin,
    input wire logic runPermitPin,
    input wire logic cmdBatchStart,
    output logic [`SPB_NUM_SP-1:0] setpointOut
);

    localparam int N = `SPB_NUM_SP;

    spb_state_t q;
    spb_state_t d;

    logic startReq;
    logic permitOk;
    logic adv;
    logic regHit;
    logic [4:0] regIdx;
    logic [`SPB_ADDR_W-1:0] regRel;
    logic [31:0] rdVal;
    logic [`SPB_NUM_SP-1:0] metV;
    logic [4:0] prevIdx;
    logic prevFound;
    logic [47:0] prod;
    logic [`SPB_VAL_W-1:0] tgt;
    logic [3:0] rk;
    logic o;

    // ****************************************************************
    // weight comparison
    // ****************************************************************
    function automatic logic weight_met(
        input logic [3:0] k,
        input logic [`SPB_VAL_W-1:0] t,
        input logic signed [`SPB_VAL_W-1:0] g,
        input logic signed [`SPB_VAL_W-1:0] n
    );
        logic signed [`SPB_VAL_W:0] w;
        logic signed [`SPB_VAL_W:0] ts;
        logic r;
        w = (k == KIND_NET || k == KIND_NNET) ? {n[`SPB_VAL_W-1], n} : {g[`SPB_VAL_W-1], g};
        ts = $signed({1'b0, t});
        r = 1'b0;
        // [R10] positive target
        if (k == KIND_GROSS || k == KIND_NET)
            r = (w >= ts);
        // [R11] negated target
        if (k == KIND_NGROSS || k == KIND_NNET)
            r = (w <= -ts);
        return r;
    endfunction

    function automatic logic is_weight(input logic [3:0] k);
        return k == KIND_GROSS || k == KIND_NET || k == KIND_NGROSS || k == KIND_NNET ||
            k == KIND_PREL;
    endfunction

    // [R7] any source starts the batch the same way
    assign startReq = (q.startS2 & ~q.startS3) | cmdBatchStart | q.userStart;
    // [R23] unassigned permit counts as active
    assign permitOk = ~q.permitAsg | q.permitS2;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        d = q;
        adv = 1'b0;
        prod = '0;
        tgt = '0;
        rk = '0;
        o = 1'b0;
        metV = '0;
        prevIdx = '0;
        prevFound = 1'b0;

        d.startS1 = batchStartPin;
        d.startS2 = q.startS1;
        d.startS3 = q.startS2;
        d.permitS1 = runPermitPin;
        d.permitS2 = q.permitS1;

        // [R24] one shared tenth-second tick
        d.tick = 1'b0;
        if (q.tickCnt == 32'(TICK_CYCLES - 1))
        begin
            d.tickCnt = '0;
            d.tick = 1'b1;
        end
        else
            d.tickCnt = q.tickCnt + 32'h1;

        // apb: one wait state so every answer comes from a flop
        regRel = paddr - `SPB_OFF_SP_BASE;
        regIdx = 5'(regRel >> 3);
        regHit = 1'b1;
        rdVal = '0;
        if (paddr == `SPB_OFF_CTRL)
            rdVal = {29'h0, q.permitAsg, q.mode};
        else if (paddr == `SPB_OFF_STATUS)
            rdVal = {q.remaining, 7'h0, q.cur, q.cntLoaded, q.jogging, q.bst};
        else if (paddr == `SPB_OFF_OUTS)
            rdVal = {12'h0, q.outQ};
        else if (paddr >= `SPB_OFF_SP_BASE && paddr < `SPB_OFF_SP_END && paddr[1:0] == 2'h0)
        begin
            if (paddr[2])
                rdVal = {8'h0, q.value[regIdx]};
            else
                rdVal = {12'h0, q.refIdx[regIdx], q.endIdx[regIdx], q.startIdx[regIdx],
                    q.member[regIdx], q.kind[regIdx]};
        end
        else
            regHit = 1'b0;

        d.preadyQ = 1'b0;
        d.pslverrQ = 1'b0;
        d.userStart = 1'b0;
        if (psel && penable && !q.preadyQ)
        begin
            d.preadyQ = 1'b1;
            d.pslverrQ = ~regHit;
            d.prdataQ = (pwrite || !regHit) ? 32'h0 : rdVal;
        end
        if (psel && penable && q.preadyQ && pwrite && regHit)
        begin
            if (paddr == `SPB_OFF_CTRL)
            begin
                d.mode = pwdata[`SPB_CTRL_MODE_LSB +: 2];
                d.permitAsg = pwdata[`SPB_CTRL_PERMIT_BIT];
                d.userStart = pwdata[`SPB_CTRL_START_BIT];
            end
            else if (paddr >= `SPB_OFF_SP_BASE)
            begin
                if (paddr[2])
                    d.value[regIdx] = pwdata[`SPB_VAL_W-1:0];
                else
                begin
                    d.kind[regIdx] = pwdata[`SPB_CFG_KIND_LSB +: 4];
                    d.member[regIdx] = pwdata[`SPB_CFG_MEMBER_BIT];
                    d.startIdx[regIdx] = pwdata[`SPB_CFG_START_LSB +: 5];
                    d.endIdx[regIdx] = pwdata[`SPB_CFG_END_LSB +: 5];
                    d.refIdx[regIdx] = pwdata[`SPB_CFG_REF_LSB +: 5];
                end
            end
        end

        // [R2] weight ports carry primary units; display units never reach here
        for (int i = 0; i < N; i++)
        begin
            rk = q.kind[i];
            tgt = q.value[i];
            // [R12] percent of the referenced target, in its weight mode
            if (q.kind[i] == KIND_PREL)
            begin
                rk = q.kind[q.refIdx[i]];
                prod = {24'h0, q.value[q.refIdx[i]]} * {24'h0, q.value[i]};
                tgt = `SPB_VAL_W'(prod / `SPB_PCT_DIV);
            end
            metV[i] = weight_met(rk, tgt, grossWeight, netWeight);
        end
        // [R3] latch every condition on each converter update
        if (weightUpdate)
            d.condQ = metV;

        // previous gross, net or negated weight setpoint (not percent) for auto-jog
        for (int j = 0; j < N; j++)
        begin
            if (5'(j) < q.cur && is_weight(q.kind[j]) && q.kind[j] != KIND_PREL)
            begin
                prevIdx = 5'(j);
                prevFound = 1'b1;
            end
        end

        d.stepEnter = 1'b0;
        unique case (q.bst)
            BST_IDLE:
            begin
                if (startReq && permitOk && q.mode != MODE_OFF)
                begin
                    d.bst = BST_RUN;
                    d.cur = '0;
                    d.stepEnter = 1'b1;
                    d.stepCnt = '0;
                    d.jogging = 1'b0;
                end
            end
            BST_RUN:
            begin
                // [R4] only the current step acts
                unique case (q.kind[q.cur])
                    KIND_GROSS, KIND_NET, KIND_NGROSS, KIND_NNET, KIND_PREL:
                        // [R5] step ends once its condition is met
                        adv = !q.member[q.cur] || q.condQ[q.cur];
                    KIND_PAUSE:
                        // [R13] wait here for a new start
                        d.bst = BST_PAUSE;
                    KIND_DELAY:
                    begin
                        // [R14] hold for value ticks
                        if (q.tick)
                            d.stepCnt = q.stepCnt + `SPB_VAL_W'(1);
                        adv = (q.stepCnt >= q.value[q.cur]);
                    end
                    KIND_STANDSTILL_WAIT_KIND:
                        // [R15] hold until standstill
                        adv = standstill;
                    KIND_SEQUENCE_COUNTER_KIND:
                    begin
                        // [R16] load the sequence count once per run
                        if (!q.cntLoaded)
                        begin
                            d.remaining = q.value[q.cur][15:0];
                            d.cntLoaded = 1'b1;
                        end
                        adv = 1'b1;
                    end
                    KIND_AUTJOG:
                    begin
                        // [R17] check at standstill, jog for value ticks when short
                        if (q.jogging)
                        begin
                            if (q.tick)
                                d.stepCnt = q.stepCnt + `SPB_VAL_W'(1);
                            if (q.stepCnt >= q.value[q.cur])
                                d.jogging = 1'b0;
                        end
                        else if (standstill)
                        begin
                            if (!prevFound || q.condQ[prevIdx])
                                adv = 1'b1;
                            else
                            begin
                                d.jogging = 1'b1;
                                d.stepCnt = '0;
                            end
                        end
                    end
                    // [R9] off, timer and concurrent kinds are no steps
                    default:
                        adv = 1'b1;
                endcase
                if (!permitOk)
                begin
                    d.bst = BST_STOP;
                    adv = 1'b0;
                end
            end
            BST_PAUSE:
            begin
                if (startReq)
                begin
                    d.bst = permitOk ? BST_RUN : BST_IDLE;
                    adv = permitOk;
                end
            end
            BST_STOP:
            begin
                if (startReq)
                    d.bst = permitOk ? BST_RUN : BST_IDLE;
            end
        endcase

        if (adv)
        begin
            d.stepCnt = '0;
            d.jogging = 1'b0;
            d.stepEnter = 1'b1;
            if (q.cur != `SPB_LAST_IDX)
                d.cur = q.cur + 5'h1;
            else
            begin
                d.cur = '0;
                // [R16] count down sequences; [R6] auto repeats, manual stops
                if (q.cntLoaded)
                begin
                    d.remaining = q.remaining - 16'h1;
                    if (q.remaining <= 16'h1)
                    begin
                        d.cntLoaded = 1'b0;
                        d.bst = BST_IDLE;
                        d.stepEnter = 1'b0;
                    end
                end
                else if (q.mode != MODE_AUTO)
                begin
                    d.bst = BST_IDLE;
                    d.stepEnter = 1'b0;
                end
            end
        end

        // [R23] start without permit resets; [R6] mode off keeps batching idle
        if ((startReq && !permitOk && q.bst != BST_RUN) || q.mode == MODE_OFF)
        begin
            d.bst = BST_IDLE;
            d.cur = '0;
            d.cntLoaded = 1'b0;
            d.jogging = 1'b0;
            d.stepEnter = 1'b0;
            d.tRun = '0;
            d.tOut = '0;
        end

        // timer and concurrent setpoints follow step entries
        for (int i = 0; i < N; i++)
        begin
            if (q.kind[i] == KIND_TIMER || q.kind[i] == KIND_CONCUR)
            begin
                if (q.stepEnter && q.cur == q.endIdx[i])
                begin
                    // [R20] end step reached
                    d.tRun[i] = 1'b0;
                    if (q.kind[i] == KIND_CONCUR)
                        d.tOut[i] = 1'b0;
                end
                else if (q.stepEnter && q.cur == q.startIdx[i])
                begin
                    d.tRun[i] = 1'b1;
                    d.tCnt[i] = '0;
                    d.tOut[i] = (q.kind[i] == KIND_CONCUR);
                end
                else if (q.tRun[i] && q.tick)
                begin
                    d.tCnt[i] = q.tCnt[i] + `SPB_VAL_W'(1);
                    // [R19] alarm on expiry before the end step
                    if (q.kind[i] == KIND_TIMER && q.tCnt[i] + `SPB_VAL_W'(1) >= q.value[i])
                    begin
                        d.tOut[i] = 1'b1;
                        d.tRun[i] = 1'b0;
                    end
                    // [R21] timed concurrent output drops on expiry
                    if (q.kind[i] == KIND_CONCUR && q.value[i] != '0 &&
                        q.tCnt[i] + `SPB_VAL_W'(1) >= q.value[i])
                    begin
                        d.tOut[i] = 1'b0;
                        d.tRun[i] = 1'b0;
                    end
                end
            end
            else
            begin
                d.tRun[i] = 1'b0;
                d.tOut[i] = 1'b0;
            end
        end

        // [R1] one registered output per setpoint
        for (int i = 0; i < N; i++)
        begin
            o = 1'b0;
            if (is_weight(q.kind[i]))
            begin
                // [R8] members are batch steps, others stay continuous
                if (q.member[i])
                    o = q.mode != MODE_OFF && q.bst == BST_RUN && q.cur == 5'(i) &&
                        !q.condQ[i];
                else
                    o = q.condQ[i];
            end
            else if (q.kind[i] == KIND_AUTJOG)
                o = q.bst == BST_RUN && q.cur == 5'(i) && q.jogging;
            else if (q.kind[i] == KIND_TIMER || q.kind[i] == KIND_CONCUR)
                o = q.tOut[i];
            // [R17] the jog pulses the related weight output too
            if (q.bst == BST_RUN && q.jogging && prevFound && prevIdx == 5'(i))
                o = 1'b1;
            d.outQ[i] = o;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            q <= '0;
        else if (ce)
            q <= d;
    end

    assign prdata = q.prdataQ;
    assign pready = q.preadyQ;
    assign pslverr = q.pslverrQ;
    assign setpointOut = q.outQ;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_off_quiet;
        ce && q.kind[0] == KIND_OFF |=> !setpointOut[0];
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("off setpoint drove output"); // [R9]

    property p_ascend;
        q.bst == BST_RUN && q.cur != $past(q.cur) |-> q.cur == $past(q.cur) + 5'h1 || ~|q.cur;
    endproperty
    a_ascend: assert property (p_ascend) else $error("batch step order broken"); // [R4]

    property p_mode_off;
        ce && q.mode == MODE_OFF |=> q.bst == BST_IDLE && q.cur == 5'h0;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("batch ran with mode off"); // [R6]

    property p_pause_hold;
        ce && q.bst == BST_PAUSE && !startReq && q.mode != MODE_OFF |=> q.bst == BST_PAUSE;
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("pause left without start"); // [R13]

    property p_wait_ss;
        ce && q.bst == BST_RUN && q.kind[q.cur] == KIND_STANDSTILL_WAIT_KIND && !standstill && permitOk
            && q.mode != MODE_OFF |=> q.cur == $past(q.cur) && !q.stepEnter;
    endproperty
    a_wait_ss: assert property (p_wait_ss) else $error("advanced without standstill"); // [R15]

    property p_delay_hold;
        ce && q.bst == BST_RUN && q.kind[q.cur] == KIND_DELAY && q.stepCnt < q.value[q.cur]
            && q.mode != MODE_OFF |=> !q.stepEnter;
    endproperty
    a_delay_hold: assert property (p_delay_hold) else $error("delay ended early"); // [R14]

    property p_met_advances;
        ce && q.bst == BST_RUN && q.member[q.cur] && is_weight(q.kind[q.cur]) &&
            q.condQ[q.cur] && permitOk && q.mode != MODE_OFF |=> q.stepEnter || q.bst == BST_IDLE;
    endproperty
    a_met_advances: assert property (p_met_advances) else $error("met step not left"); // [R5]

    property p_no_permit_reset;
        ce && startReq && !permitOk && q.bst != BST_RUN |=> q.bst == BST_IDLE && q.cur == 5'h0;
    endproperty
    a_no_permit_reset: assert property (p_no_permit_reset) else $error("reset skipped"); // [R23]

    property p_cont_follow;
        ce && weightUpdate && q.kind[0] == KIND_GROSS && !q.member[0] ##1 ce |=>
            setpointOut[0] == ($past(grossWeight, 2) >= $signed({1'b0, $past(q.value[0], 2)}));
    endproperty
    a_cont_follow: assert property (p_cont_follow) else $error("continuous output stale"); // [R3]

endmodule // spb_sequencer

`default_nettype wire

// ---- include/spb_cfg.svh ----
// constants of the setpoint and batch sequencer: offsets, field positions, timing
// assumes a 250 MHz system clock and a 32-bit APB register port
//
// Overview of operation
// [R1] twenty setpoints, each able to drive its own output or trigger a function
// [R2] weight setpoints compare against weight in primary units only
// [R3] continuous setpoints re-evaluate on every converter update and follow the condition
// [R4] batch steps run one at a time in ascending order, up to twenty
// [R5] batch step output active until condition met, then latched off for the sequence
// [R6] mode off disables batching, auto repeats after one start, manual needs each start
// [R7] pin, serial command or user program start requests act identically
// [R8] dual-use kinds join the batch only with member flag, else continuous
// [R9] off kind takes no part in continuous or batch operation
// [R10] gross and net kinds compare against a positive target
// [R11] negative gross and net kinds compare against a negated target
// [R12] percent kind targets a percentage of a referenced setpoint, same weight mode
// [R13] pause step halts the sequence until a new start request
// [R14] delay step holds the sequence for value tenths of a second
// [R15] standstill-wait step holds the sequence until standstill is reported
// [R16] counter step sets how many consecutive sequences are run
// [R17] auto-jog pulses previous weight setpoint output until satisfied at standstill
// [R18] configuration should give auto-jog its own output, separate from the weight one
// [R19] timer kind raises its output if end step not reached before expiry
// [R20] concurrent kind with zero value is active from start step to end step
// [R21] concurrent kind with nonzero value is active for value tenths from start step
// [R22] timer, concurrent and continuous setpoints should sit outside referenced ranges
// [R23] start with permit runs or resumes, start without permit resets the batch
// [R24] all durations count one shared tenth-of-a-second tick from the system clock
`ifndef SPB_CFG_SVH
`define SPB_CFG_SVH

`define SPB_NUM_SP 20
`define SPB_LAST_IDX 5'h13
`define SPB_VAL_W 24
`define SPB_CLK_NS 4
`define SPB_TICK_NS 100000000
`define SPB_PCT_DIV 48'h64

`define SPB_ADDR_W 12
`define SPB_OFF_CTRL 12'h000
`define SPB_OFF_STATUS 12'h004
`define SPB_OFF_OUTS 12'h008
`define SPB_OFF_SP_BASE 12'h100
`define SPB_OFF_SP_END 12'h1A0

`define SPB_CTRL_MODE_LSB 0
`define SPB_CTRL_PERMIT_BIT 2
`define SPB_CTRL_START_BIT 3
`define SPB_ST_STATE_LSB 0
`define SPB_ST_JOG_BIT 2
`define SPB_ST_CNT_BIT 3
`define SPB_ST_STEP_LSB 4
`define SPB_ST_REMAIN_LSB 16
`define SPB_CFG_KIND_LSB 0
`define SPB_CFG_MEMBER_BIT 4
`define SPB_CFG_START_LSB 5
`define SPB_CFG_END_LSB 10
`define SPB_CFG_REF_LSB 15

`endif

// ---- include/spb_pkg.sv ----
// types of the setpoint and batch sequencer
// assumes spb_cfg.svh sits on the include path
`include "spb_cfg.svh"

package spb_pkg;

    typedef enum logic [3:0] {
        KIND_OFF = 4'h0, KIND_GROSS = 4'h1, KIND_NET = 4'h2, KIND_NGROSS = 4'h3,
        KIND_NNET = 4'h4, KIND_PREL = 4'h5, KIND_PAUSE = 4'h6, KIND_DELAY = 4'h7,
        KIND_STANDSTILL_WAIT_KIND = 4'h8, KIND_SEQUENCE_COUNTER_KIND = 4'h9, KIND_AUTJOG = 4'hA, KIND_TIMER = 4'hB,
        KIND_CONCUR = 4'hC
    } spb_kind_t;

    typedef enum logic [1:0] {
        MODE_OFF = 2'h0, MODE_AUTO = 2'h1, MODE_MANUAL = 2'h2
    } spb_mode_t;

    // gray along idle -> run -> pause -> stop
    typedef enum logic [1:0] {
        BST_IDLE = 2'h0, BST_RUN = 2'h1, BST_PAUSE = 2'h3, BST_STOP = 2'h2
    } spb_bst_t;

    typedef struct packed {
        logic [`SPB_NUM_SP-1:0][3:0] kind;
        logic [`SPB_NUM_SP-1:0] member;
        logic [`SPB_NUM_SP-1:0][4:0] startIdx;
        logic [`SPB_NUM_SP-1:0][4:0] endIdx;
        logic [`SPB_NUM_SP-1:0][4:0] refIdx;
        logic [`SPB_NUM_SP-1:0][`SPB_VAL_W-1:0] value;
        logic [`SPB_NUM_SP-1:0][`SPB_VAL_W-1:0] tCnt;
        logic [`SPB_NUM_SP-1:0] condQ;
        logic [`SPB_NUM_SP-1:0] tRun;
        logic [`SPB_NUM_SP-1:0] tOut;
        logic [`SPB_NUM_SP-1:0] outQ;
        logic [1:0] mode;
        logic permitAsg;
        spb_bst_t bst;
        logic [4:0] cur;
        logic stepEnter;
        logic [`SPB_VAL_W-1:0] stepCnt;
        logic jogging;
        logic cntLoaded;
        logic [15:0] remaining;
        logic [31:0] tickCnt;
        logic tick;
        logic startS1;
        logic startS2;
        logic startS3;
        logic permitS1;
        logic permitS2;
        logic userStart;
        logic preadyQ;
        logic pslverrQ;
        logic [31:0] prdataQ;
    } spb_state_t;

endpackage

// ---- testbench/spb_hopper_model.sv ----
// hopper model: fills while the feed valve output is on, reports weight each update
// assumes the feed valve is setpoint output 2 and weight is in primary units
`timescale 1ns/1ps
`default_nettype none
module spb_hopper_model (
    input wire logic clk,
    input wire logic feed,
    input wire logic loadEn,
    input wire logic signed [23:0] loadVal,
    output logic signed [23:0] grossWeight,
    output logic signed [23:0] netWeight,
    output logic weightUpdate,
    output logic standstill
);
    logic [1:0] div = 2'h0;
    initial grossWeight = 24'sh0;
    initial weightUpdate = 1'b0;
    always @(posedge clk)
    begin
        div <= div + 2'h1;
        weightUpdate <= (div == 2'h3);
        if (loadEn)
            grossWeight <= loadVal;
        else if (feed && div == 2'h3)
            grossWeight <= grossWeight + 24'sh10;
    end
    // fixed tare of 0x40, so net runs below gross
    assign netWeight = grossWeight - 24'sh40;
    // only the fill output drives the valve; a jog step also pulses the previous weight output
    // scale settles as soon as the valve closes
    assign standstill = !feed;
endmodule // spb_hopper_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// directed bench for the setpoint sequencer over apb
// assumes the hopper model on the weight side and a 4-cycle tick
`timescale 1ns/1ps
`default_nettype none
`include "spb_cfg.svh"
module tb_top;
    logic clk = 1'b0, sysRst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdData;
    logic pready, pslverr, errQ, upd, still, loadEn = 1'b0;
    logic startPin = 1'b0, permitPin = 1'b0, cmdStart = 1'b0;
    logic [19:0] outs;
    logic signed [23:0] gross, net, loadVal = 24'sh0;
    int fail_count = 0, checks_done = 0, cycles = 0;
    initial forever #2 clk = ~clk;
    spb_sequencer #(.TICK_CYCLES(4)) DUT (.clk(clk), .sys_rst(sysRst), .ce(1'b1),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .grossWeight(gross),
        .netWeight(net), .weightUpdate(upd), .standstill(still), .batchStartPin(startPin),
        .runPermitPin(permitPin), .cmdBatchStart(cmdStart), .setpointOut(outs));
    spb_hopper_model hopper (.clk(clk), .feed(outs[2]), .loadEn(loadEn), .loadVal(loadVal),
        .grossWeight(gross), .netWeight(net), .weightUpdate(upd), .standstill(still));
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // pready ends this wait; only the bench ceiling stops a hang
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdData = prdata;
        errQ = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rdData, exp);
    endtask
    task automatic stChk(input logic [1:0] exp);
        xfer(`SPB_OFF_STATUS, 1'b0, 32'h0);
        chk({30'h0, rdData[1:0]}, {30'h0, exp});
    endtask
    task automatic setW(input logic signed [23:0] v);
        loadVal <= v;
        loadEn <= 1'b1;
        @(posedge clk);
        loadEn <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ceiling well above the directed sequence length
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            complete_run();
        end
    end
    initial
    begin
        int n;
        repeat (5) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        rdChk(`SPB_OFF_CTRL, 32'h0);
        rdChk(`SPB_OFF_OUTS, 32'h0);
        xfer(12'h00C, 1'b0, 32'h0);
        chk({31'h0, errQ}, 32'h1);
        // continuous gross >= 0x100 on sp0, negative net <= -0x20 on sp1
        xfer(`SPB_OFF_SP_BASE, 1'b1, 32'h1);
        xfer(`SPB_OFF_SP_BASE + 12'h4, 1'b1, 32'h100);
        xfer(`SPB_OFF_SP_BASE + 12'h8, 1'b1, 32'h4);
        xfer(`SPB_OFF_SP_BASE + 12'hC, 1'b1, 32'h20);
        setW(24'sh10);
        rdChk(`SPB_OFF_OUTS, 32'h2);
        setW(24'sh180);
        rdChk(`SPB_OFF_OUTS, 32'h1);
        setW(24'sh40);
        // batch: sp2 fill to 0xC0, sp3 delay 3, sp4 off, sp5 concur over steps 2..3
        xfer(`SPB_OFF_SP_BASE + 12'h10, 1'b1, 32'h11);
        xfer(`SPB_OFF_SP_BASE + 12'h14, 1'b1, 32'hC0);
        xfer(`SPB_OFF_SP_BASE + 12'h18, 1'b1, 32'h7);
        xfer(`SPB_OFF_SP_BASE + 12'h1C, 1'b1, 32'h3);
        // sp5 sits outside the range it references
        xfer(`SPB_OFF_SP_BASE + 12'h28, 1'b1, 32'hC | (32'h2 << 5) | (32'h3 << 10));
        xfer(`SPB_OFF_CTRL, 1'b1, 32'h2);
        cmdStart <= 1'b1;
        @(posedge clk);
        cmdStart <= 1'b0;
        repeat (3) @(posedge clk);
        stChk(2'h1);
        rdChk(`SPB_OFF_OUTS, 32'h24);
        for (n = 0; n < 100; n++)
        begin
            xfer(`SPB_OFF_STATUS, 1'b0, 32'h0);
            if (rdData[1:0] == 2'h0)
                break;
        end
        stChk(2'h0);
        rdChk(`SPB_OFF_OUTS, 32'h0);
        // mode off: a pin start must change nothing
        xfer(`SPB_OFF_CTRL, 1'b1, 32'h0);
        startPin <= 1'b1;
        repeat (6) @(posedge clk);
        startPin <= 1'b0;
        stChk(2'h0);
        // sp4 becomes a pause step for the auto run
        xfer(`SPB_OFF_SP_BASE + 12'h20, 1'b1, 32'h6);
        permitPin <= 1'b1;
        xfer(`SPB_OFF_CTRL, 1'b1, 32'hD);
        repeat (2) @(posedge clk);
        stChk(2'h1);
        repeat (20) @(posedge clk);
        stChk(2'h3);
        // pin start resumes the pause, then permit loss stops the run
        startPin <= 1'b1;
        repeat (4) @(posedge clk);
        startPin <= 1'b0;
        permitPin <= 1'b0;
        repeat (6) @(posedge clk);
        stChk(2'h2);
        xfer(`SPB_OFF_CTRL, 1'b1, 32'hD);
        repeat (2) @(posedge clk);
        stChk(2'h0);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
